// ---- bench/dswr_bus_master.sv ----
// Bus master model for the two-wire link
`timescale 1ns/100ps
module dswr_bus_master (
    input  wire logic clk,
    input  wire logic sda_wire,
    output logic      scl = 1'b1,
    output logic      sda = 1'b1
);
    // All driving happens at the falling clock edge
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w
    // Start (b high) or stop (b low); the long wait lets a held acknowledge end
    task automatic cond(input logic b);
        sda = b;
        w(6);
        scl = 1'b1;
        w(4);
        sda = ~b;
        w(4);
        scl = ~b;
        w(1);
    endtask : cond
    // One bit at 320 ns: data set while low, sampled late in the high phase
    task automatic bit_out(input logic b, output logic s);
        sda = b;
        w(4);
        scl = 1'b1;
        w(3);
        s = sda_wire;
        scl = 1'b0;
        w(1);
    endtask : bit_out
    // Byte sent top bit first, ninth clock with data released
    task automatic wr(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_out(d[i], s);
        bit_out(1'b1, s);
        ack = ~s;
    endtask : wr
endmodule : dswr_bus_master

// ---- bench/dswr_receiver_props.sv ----
// Port checks for the two-wire write receiver
`timescale 1ns/100ps
module dswr_receiver_props (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic       update_pulse,
    input wire logic [1:0] update_channel,
    input wire logic [9:0] update_data,
    input wire logic       bus_busy
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_one; update_pulse |=> !update_pulse; endproperty
    a_one: assert property (p_one) else $error("Update strobe too long");
    // Fields may only move together with the strobe
    property p_hold; !update_pulse |-> $stable(update_data) && $stable(update_channel); endproperty
    a_hold: assert property (p_hold) else $error("Update fields moved without strobe");
    property p_busy; update_pulse |-> bus_busy; endproperty
    a_busy: assert property (p_busy) else $error("Update outside a transaction");
    property p_idle; !bus_busy |-> sda_oe_n; endproperty
    a_idle: assert property (p_idle) else $error("Data line pulled on an idle bus");
    // Acknowledge is a low level and only ever inside a transaction
    property p_drive; !sda_oe_n |-> (sda_out == 1'b0) && bus_busy; endproperty
    a_drive: assert property (p_drive) else $error("Acknowledge outside a transaction");
    // Acknowledge must outlast the clock fall that ends its bit
    property p_stand; $fell(scl_in) && !sda_oe_n |-> !sda_oe_n [*3]; endproperty
    a_stand: assert property (p_stand) else $error("Acknowledge released too early");
    property p_start; $fell(sda_in) && scl_in && $past(scl_in) |-> ##[2:8] bus_busy; endproperty
    a_start: assert property (p_start) else $error("Start not seen");
    property p_stop; $rose(sda_in) && scl_in && $past(scl_in) |-> ##[2:8] !bus_busy; endproperty
    a_stop: assert property (p_stop) else $error("Stop not seen");
    // Strobe follows the clock fall, never the rise
    property p_late; update_pulse |-> $past(scl_in, 3) == 1'b0; endproperty
    a_late: assert property (p_late) else $error("Update before ack clock fall");
    c_upd: cover property (update_pulse);
    c_ack: cover property ($fell(sda_oe_n));
    c_busy: cover property ($rose(bus_busy));
endmodule : dswr_receiver_props

// ---- bench/tb_dswr_receiver.sv ----
// Bench for the two-wire write receiver
`timescale 1ns/100ps
`include "dswr_params.svh"
module tb_dswr_receiver;
    logic       clk = 1'b0, rstn = 1'b0, ack, scl, sda_m, sda_out, sda_oe_n, upd, pdf, busy;
    logic       pa_hi = 1'b1, pa_lo = 1'b0, ea_hi = 1'b0, ea_lo = 1'b1; // Strap pins, moved by t_pins
    logic [1:0] ch, lm, pdm;
    logic [9:0] dat;
    int         miscompares = 0, checked = 0, npulse = 0, cycles = 0;
    wire        sda_wire = sda_m & (sda_oe_n | sda_out); // Pull-up unless someone pulls low
    wire  [7:0] addr = {`DSWR_ADDR_FIXED, pa_hi, pa_lo, 1'b0}; // Write address for the present straps
    always #20 clk = ~clk;
    // Counts strobes and cuts a hang short; a full run needs about 5100 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (upd === 1'b1) npulse <= npulse + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    dswr_bus_master m (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda(sda_m));
    dswr_receiver uut (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .pin_addr_bit_hi(pa_hi), .pin_addr_bit_lo(pa_lo), .ext_addr_bit_hi(ea_hi),
        .ext_addr_bit_lo(ea_lo), .update_pulse(upd), .update_channel(ch), .update_load_mode(lm),
        .update_is_powerdown(pdf), .update_powerdown_mode(pdm), .update_data(dat), .bus_busy(busy));
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic head(input logic [7:0] c);
        m.cond(1'b1);
        m.wr(addr, ack);
        chk("addr ack", 10'h1, 10'(ack));
        m.wr(c, ack);
        chk("ctrl ack", 10'h1, 10'(ack));
    endtask : head
    // One high/low pair, then one strobe carrying the control fields
    task automatic pair(input logic [7:0] c, h, l);
        int n;
        n = npulse + 1;
        m.wr(h, ack);
        chk("high ack", 10'h1, 10'(ack));
        m.wr(l, ack);
        chk("low ack", 10'h1, 10'(ack));
        m.w(6);
        chk("strobes", 10'(n), 10'(npulse));
        chk("channel", 10'(c[2:1]), 10'(ch));
        chk("load", 10'(c[5:4]), 10'(lm));
        chk("pd flag", 10'(c[0]), 10'(pdf));
        if (c[0]) chk("pd mode", 10'(h[7:6]), 10'(pdm));
        else chk("data", {h, l[7:6]}, dat);
    endtask : pair
    // Back-to-back pairs, every channel and load code, closed by restart or stop
    task automatic t_data();
        logic [7:0] c;
        for (int k = 0; k < 4; k++) begin
            c = {2'b01, 2'(k), 1'b0, 2'(3 - k), 1'b0};
            head(c);
            pair(c, 8'h5a ^ 8'(k), 8'hc0 >> k);
            pair(c, 8'ha5, 8'(k << 6));
            if (k[0]) m.cond(1'b0);
        end
    endtask : t_data
    // Every power-down mode; a third byte is refused
    task automatic t_pd();
        logic [7:0] c;
        for (int k = 0; k < 4; k++) begin
            c = {4'h5, 1'b0, 2'(k), 1'b1};
            head(c);
            pair(c, {2'(k), 6'h0}, 8'h00);
            m.wr(8'h00, ack);
            chk("extra ack", 10'h0, 10'(ack));
            m.cond(1'b0);
        end
    endtask : t_pd
    // Master code, read bit, foreign pin address and foreign extended bits
    task automatic t_refuse();
        int n;
        m.cond(1'b1);
        m.wr(8'h0b, ack);
        chk("mcode ack", 10'h0, 10'(ack));
        head(8'h40);
        pair(8'h40, 8'hff, 8'hc0);
        n = npulse;
        for (int k = 0; k < 2; k++) begin
            m.cond(1'b1);
            m.wr(k ? addr ^ 8'h04 : addr | 8'h01, ack);
            chk("bad addr ack", 10'h0, 10'(ack));
            m.wr(8'h40, ack);
            chk("ignored ack", 10'h0, 10'(ack));
        end
        head(8'h80);
        m.wr(8'h12, ack);
        chk("foreign ext ack", 10'h1, 10'(ack));
        m.wr(8'h40, ack);
        m.cond(1'b0);
        chk("no strobe", 10'(n), 10'(npulse));
    endtask : t_refuse
    // New strap levels: the old address is refused, the new one and new extended bits act
    task automatic t_pins();
        logic [7:0] old;
        old = addr;
        {pa_hi, pa_lo, ea_hi, ea_lo} = 4'b0110;
        m.cond(1'b1);
        m.wr(old, ack);
        chk("old addr ack", 10'h0, 10'(ack));
        head(8'h94);
        pair(8'h94, 8'h3c, 8'h80);
        m.cond(1'b0);
    endtask : t_pins
    // Reset in mid-frame clears the outputs and forgets the frame
    task automatic t_rst();
        head(8'h80);
        m.w(8);
        rstn = 1'b0;
        m.w(4);
        chk("reset busy", 10'h0, 10'(busy));
        rstn = 1'b1;
        m.w(8);
        chk("reset oe", 10'h1, 10'(sda_oe_n));
        chk("reset data", 10'h0, dat);
        m.cond(1'b0);
        chk("busy after stop", 10'h0, 10'(busy));
    endtask : t_rst
    task automatic end_of_test();
        $display("Comparisons %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        m.w(8);
        chk("reset oe", 10'h1, 10'(sda_oe_n));
        chk("reset data", 10'h0, dat);
        t_data();
        t_pd();
        t_refuse();
        t_pins();
        t_rst();
        end_of_test();
    end
endmodule : tb_dswr_receiver
bind dswr_receiver dswr_receiver_props chk_i (.clk(clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .update_pulse(update_pulse), .update_channel(update_channel),
    .update_data(update_data), .bus_busy(bus_busy));

// ---- hdl/dswr_params.svh ----
// Constants for the two-wire write receiver
// What this block does
// [R1] Write address 10011 plus pins, write bit zero
// [R2] Control byte: ext addr, load, x, channel, select
// [R3] Control bit 0 picks data or power-down bytes
// [R4] Data mode: high/low pairs until stop or restart
// [R5] Master puts bits 9..2 high, 1..0 low top
// [R6] Power-down select: exactly two bytes follow
// [R7] Acknowledge address, control and data bytes
// [R8] Master code 0000 1xxx never acknowledged
// [R9] Master restarts at high speed, same sequence
// [R10] Master should end writes with repeated start
// [R11] Update on ack clock fall after low byte
// [R12] Extended address bits must match ext pins
// [R13] Wrong pin address: no ack, transaction ignored
`ifndef DSWR_PARAMS_SVH
`define DSWR_PARAMS_SVH
`define DSWR_ADDR_FIXED     5'h13
`define DSWR_MCODE_TOP      5'h01
`define DSWR_CTL_EXT_HI     7
`define DSWR_CTL_EXT_LO     6
`define DSWR_CTL_LOAD_HI    5
`define DSWR_CTL_LOAD_LO    4
`define DSWR_CTL_CH_HI      2
`define DSWR_CTL_CH_LO      1
`define DSWR_CTL_PD_SEL     0
`define DSWR_SYNC_DEPTH     3
`endif

// ---- hdl/dswr_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module dswr_pin_sync (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic pin_in,
    output logic      level_out
);
    // Stage one feeds only stage two; output moves when two and three agree
    logic [2:0] sync_reg;
    logic       level_reg;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync_reg  <= 3'h7;
            level_reg <= 1'b1;
        end else begin
            sync_reg <= {sync_reg[1:0], pin_in};
            if (sync_reg[1] == sync_reg[2]) begin
                level_reg <= sync_reg[2];
            end
        end
    end
    assign level_out = level_reg;
endmodule : dswr_pin_sync

// ---- hdl/dswr_pkg.sv ----
// Types for the two-wire write receiver
package dswr_pkg;
    typedef enum logic [2:0] {
        DSWR_IDLE  = 3'b000,
        DSWR_ADDR  = 3'b001,
        DSWR_CTRL  = 3'b010,
        DSWR_HIGH  = 3'b011,
        DSWR_LOW   = 3'b100,
        DSWR_IGN   = 3'b101
    } dswr_phase_t;
endpackage : dswr_pkg

// ---- hdl/dswr_receiver.sv ----
// Two-wire serial write receiver for a quad 10-bit converter
`timescale 1ns/100ps
`include "dswr_params.svh"
module dswr_receiver
    import dswr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic       pin_addr_bit_hi,
    input  wire logic       pin_addr_bit_lo,
    input  wire logic       ext_addr_bit_hi,
    input  wire logic       ext_addr_bit_lo,
    output logic            update_pulse,
    output logic [1:0]      update_channel,
    output logic [1:0]      update_load_mode,
    output logic            update_is_powerdown,
    output logic [1:0]      update_powerdown_mode,
    output logic [9:0]      update_data,
    output logic            bus_busy
);
    // State of the receiver past the pin filters in one record
    typedef struct packed {
        // Frame phase and the previous filtered line levels
        dswr_phase_t phase;
        logic        scl_d;
        logic        sda_d;
        // Byte assembly: shift register and bit count, nine with the acknowledge clock
        logic [7:0]  shift;
        logic [3:0]  bitcnt;
        // Acknowledge drive, its decision, a pending update and the bus-held flag
        logic        ack_on;
        logic        ack_then;
        logic        pend_upd;
        logic        busy;
        // Control fields latched from the control byte
        logic [1:0]  chan;
        logic [1:0]  load;
        logic        pd_sel;
        logic        ext_ok;
        // First byte of a pair, held until its partner arrives
        logic [7:0]  hi_byte;
        // Registered update outputs
        logic        upd;
        logic [1:0]  upd_ch;
        logic [1:0]  upd_ld;
        logic        upd_pd;
        logic [1:0]  upd_pdm;
        logic [9:0]  upd_data;
    } dswr_state_t;

    dswr_state_t st_reg;   // Registered state
    dswr_state_t st_next;  // Next state
    logic        scl_s;    // Filtered clock level
    logic        sda_s;    // Filtered data level

    // Both bus lines are filtered; the 320 ns bus period gives 8 samples per cycle
    dswr_pin_sync u_scl_sync (
        .clk       (clk),
        .rstn      (rstn),
        .pin_in    (scl_in),
        .level_out (scl_s)
    );
    dswr_pin_sync u_sda_sync (
        .clk       (clk),
        .rstn      (rstn),
        .pin_in    (sda_in),
        .level_out (sda_s)
    );

    // Strap pins are asynchronous too; a strap moved mid-frame must not split a compare
    // Order: pin address high, pin address low, extended high, extended low
    logic [3:0] strap_raw;  // Strap pins as they arrive
    logic [3:0] strap_s;    // Filtered strap levels
    assign strap_raw = {pin_addr_bit_hi, pin_addr_bit_lo, ext_addr_bit_hi, ext_addr_bit_lo};
    for (genvar g = 0; g < 4; g++) begin : g_strap
        dswr_pin_sync u_strap_sync (
            .clk       (clk),
            .rstn      (rstn),
            .pin_in    (strap_raw[g]),
            .level_out (strap_s[g])
        );
    end

    // Address byte match: fixed top bits, pin bits, write direction
    function automatic logic addr_match(input logic [7:0] b, input logic a1, input logic a0);
        addr_match = (b[7:3] == `DSWR_ADDR_FIXED) && (b[2] == a1) && (b[1] == a0) && !b[0]; // [R1] [R13]
    endfunction : addr_match

    // Edge and condition flags, rebuilt from the filtered levels every cycle
    logic scl_rise;  // Clock rising edge
    logic scl_fall;  // Clock falling edge
    logic start_c;   // Start or repeated start
    logic stop_c;    // Stop

    // Next-state logic: conditions, bit shifting, byte decode and acknowledge
    always_comb begin
        st_next       = st_reg;
        st_next.scl_d = scl_s;
        st_next.sda_d = sda_s;
        st_next.upd   = 1'b0;
        scl_rise = scl_s && !st_reg.scl_d;
        scl_fall = !scl_s && st_reg.scl_d;
        start_c  = scl_s && st_reg.scl_d && st_reg.sda_d && !sda_s;
        stop_c   = scl_s && st_reg.scl_d && !st_reg.sda_d && sda_s;
        if (start_c) begin
            // A restart ends any data stream and goes back to addressing
            st_next.phase    = DSWR_ADDR; // [R4]
            st_next.bitcnt   = 4'h0;
            st_next.ack_on   = 1'b0;
            st_next.pend_upd = 1'b0;
            st_next.busy     = 1'b1;
        end else if (stop_c) begin
            // Stop frees the bus and drops a half-received pair
            st_next.phase    = DSWR_IDLE; // [R4]
            st_next.ack_on   = 1'b0;
            st_next.pend_upd = 1'b0;
            st_next.busy     = 1'b0;
        end else if (st_reg.phase != DSWR_IDLE && st_reg.phase != DSWR_IGN) begin
            if (scl_rise && st_reg.bitcnt < 4'h8) begin
                // Sample a data bit, most significant first
                st_next.shift  = {st_reg.shift[6:0], sda_s};
                st_next.bitcnt = st_reg.bitcnt + 4'h1;
            end else if (scl_fall && st_reg.bitcnt == 4'h8) begin
                // Eighth bit done: decide the acknowledge for the ninth clock
                st_next.bitcnt   = 4'h9;
                st_next.ack_then = 1'b1;
                case (st_reg.phase)
                    DSWR_ADDR: begin
                        // Master code and foreign addresses stay unacknowledged
                        if (st_reg.shift[7:3] == `DSWR_MCODE_TOP) begin
                            st_next.ack_then = 1'b0; // [R8]
                            st_next.phase    = DSWR_IGN; // [R9]
                        end else if (addr_match(st_reg.shift, strap_s[3], strap_s[2])) begin
                            // Pins are compared through their filters, never raw
                            st_next.phase = DSWR_CTRL; // [R1]
                        end else begin
                            // Rest of the frame is ignored until the next start or stop
                            st_next.ack_then = 1'b0;
                            st_next.phase    = DSWR_IGN; // [R13]
                        end
                    end
                    DSWR_CTRL: begin
                        // Latch control fields; extended bits must match the pins
                        // A mismatch is still acknowledged, but no update follows
                        st_next.ext_ok = (st_reg.shift[`DSWR_CTL_EXT_HI] == strap_s[1]) &&
                                         (st_reg.shift[`DSWR_CTL_EXT_LO] == strap_s[0]); // [R12]
                        st_next.load   = st_reg.shift[`DSWR_CTL_LOAD_HI:`DSWR_CTL_LOAD_LO]; // [R2]
                        st_next.chan   = st_reg.shift[`DSWR_CTL_CH_HI:`DSWR_CTL_CH_LO]; // [R2]
                        st_next.pd_sel = st_reg.shift[`DSWR_CTL_PD_SEL]; // [R3]
                        st_next.phase  = DSWR_HIGH;
                    end
                    DSWR_HIGH: begin
                        // Keep the first byte of the pair until its partner arrives
                        st_next.hi_byte = st_reg.shift;
                        st_next.phase   = DSWR_LOW;
                    end
                    DSWR_LOW: begin
                        // Low byte done; update fires on the ack clock's fall
                        st_next.pend_upd = st_reg.ext_ok; // [R11]
                        // Power-down takes exactly two bytes; data pairs repeat
                        st_next.phase    = st_reg.pd_sel ? DSWR_IGN : DSWR_HIGH; // [R6] [R4]
                    end
                    default: st_next.phase = DSWR_IGN;
                endcase
                st_next.ack_on = st_next.ack_then; // [R7]
            end else if (scl_fall && st_reg.bitcnt == 4'h9) begin
                // Ninth clock ends: release the line, fire any pending update
                st_next.bitcnt   = 4'h0;
                st_next.ack_on   = 1'b0;
                st_next.pend_upd = 1'b0;
                if (st_reg.pend_upd) begin
                    st_next.upd      = 1'b1; // [R11]
                    st_next.upd_ch   = st_reg.chan;
                    st_next.upd_ld   = st_reg.load;
                    st_next.upd_pd   = st_reg.pd_sel; // [R3]
                    // Data bits 9..2 from high byte, 1..0 from low byte top
                    st_next.upd_data = {st_reg.hi_byte, st_reg.shift[7:6]}; // [R5]
                    // Mode bits sit in the first power-down byte's top two bits
                    st_next.upd_pdm  = st_reg.hi_byte[7:6]; // [R6]
                end
            end
        end else if (st_reg.phase == DSWR_IGN && st_reg.ack_on && scl_fall && st_reg.bitcnt == 4'h9) begin
            // Release the last acknowledge of a finished power-down write
            st_next.ack_on = 1'b0;
            st_next.bitcnt = 4'h0;
            st_next.upd    = st_reg.pend_upd;
            st_next.pend_upd = 1'b0;
            if (st_reg.pend_upd) begin
                st_next.upd_ch  = st_reg.chan;
                st_next.upd_ld  = st_reg.load;
                st_next.upd_pd  = 1'b1;
                st_next.upd_pdm = st_reg.hi_byte[7:6]; // [R6] [R11]
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            // Lines read as released after reset, so no false start follows it
            st_reg       <= '0;
            st_reg.phase <= DSWR_IDLE;
            st_reg.scl_d <= 1'b1;
            st_reg.sda_d <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Open-drain drive: enable low pulls the line low
    assign sda_out               = 1'b0;
    assign sda_oe_n              = !st_reg.ack_on; // [R7]
    // Update fields come straight from flops and hold between strobes
    assign update_pulse          = st_reg.upd;
    assign update_channel        = st_reg.upd_ch;
    assign update_load_mode      = st_reg.upd_ld;
    assign update_is_powerdown   = st_reg.upd_pd;
    assign update_powerdown_mode = st_reg.upd_pdm;
    assign update_data           = st_reg.upd_data;
    assign bus_busy              = st_reg.busy;
endmodule : dswr_receiver
